// ### pci_edge.sv
// per-pin rising and falling edge detectors of one port
`timescale 1ns/1ns
module pci_edge
    import pci_pkg::*;
(
    // clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // synchronised pins and enables
    input  wire logic [PCI_PORT_WIDTH-1:0]  pin_sync,
    input  wire pci_pkg::pci_edge_cfg_t     cfg,
    // one-cycle detection per pin
    output logic      [PCI_PORT_WIDTH-1:0]  hit
);
    import pci_pkg::*;

    logic [PCI_PORT_WIDTH-1:0] prev_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prev_q <= PCI_ZERO8;
        else
            prev_q <= pin_sync;
    end

    genvar i;
    generate
        for (i = 0; i < PCI_PORT_WIDTH; i++)
        begin : g_pin
            // either direction may be armed; both armed flags both
            assign hit[i] = (cfg.rise[i] & pin_sync[i] & ~prev_q[i])
                          | (cfg.fall[i] & ~pin_sync[i] & prev_q[i]);
        end
    endgenerate
endmodule

// ### pci_pin_model.sv
// far-side model that drives the port pins with a programmable lag
`timescale 1ns/1ns
module pci_pin_model
(
    // clock and reset
    input  wire logic       pclk,
    input  wire logic       presetn,
    // requested levels and lag in cycles
    input  wire logic [7:0] next_a,
    input  wire logic [7:0] next_b,
    input  wire logic [1:0] lag,
    // pins
    output logic      [7:0] porta_pin,
    output logic      [7:0] portb_pin
);
    logic [1:0] cnt_q;

    // pins follow the requested levels once lag cycles have passed
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_q     <= 2'h0;
            porta_pin <= 8'h00;
            portb_pin <= 8'h00;
        end
        else if (next_a == porta_pin && next_b == portb_pin)
            cnt_q <= 2'h0;
        else if (cnt_q >= lag)
        begin
            cnt_q     <= 2'h0;
            porta_pin <= next_a;
            portb_pin <= next_b;
        end
        else
            cnt_q <= cnt_q + 2'h1;
    end
endmodule

// ### pci_pkg.sv
// package: register map, field masks and carrier types of the pin-change block
package pci_pkg;

    // register byte offsets
    localparam logic [11:0] PCI_PORTA_RISE_OFF  = 12'h000;
    localparam logic [11:0] PCI_PORTA_FALL_OFF  = 12'h004;
    localparam logic [11:0] PCI_PORTA_FLAG_OFF  = 12'h008;
    localparam logic [11:0] PCI_PORTB_RISE_OFF  = 12'h00c;
    localparam logic [11:0] PCI_PORTB_FALL_OFF  = 12'h010;
    localparam logic [11:0] PCI_PORTB_FLAG_OFF  = 12'h014;
    localparam logic [11:0] PCI_INTCTL_OFF      = 12'h018;
    localparam logic [11:0] PCI_IRQ_STATUS_OFF  = 12'h01c;
    localparam logic [11:0] PCI_IRQ_CLEAR_OFF   = 12'h020;
    localparam logic [11:0] PCI_IRQ_ENABLE_OFF  = 12'h024;

    // implemented bits of each port
    localparam logic [7:0]  PCI_PORTA_MASK      = 8'h3f;
    localparam logic [7:0]  PCI_PORTB_MASK      = 8'hf0;
    localparam logic [7:0]  PCI_ZERO8           = 8'h00;
    localparam logic [31:0] PCI_ZERO32          = 32'h0000_0000;

    // interrupt control register fields
    localparam int          PCI_INTCTL_MEN_BIT  = 3;
    localparam int          PCI_INTCTL_SUM_BIT  = 0;

    // event status bits
    localparam int          PCI_EV_PORTA_BIT    = 0;
    localparam int          PCI_EV_PORTB_BIT    = 1;
    localparam int          PCI_EV_WIDTH        = 2;
    localparam logic [1:0]  PCI_EV_ZERO         = 2'h0;

    localparam int          PCI_PORT_WIDTH      = 8;

    // rise and fall enables of one port
    typedef struct packed {
        logic [7:0] rise;
        logic [7:0] fall;
    } pci_edge_cfg_t;

    // apb request carrier
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pci_apb_req_t;

endpackage

// ### pci_sync.sv
// two-flop synchroniser for the port pins
`timescale 1ns/1ns
module pci_sync
    import pci_pkg::*;
(
    // clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // pins
    input  wire logic [PCI_PORT_WIDTH-1:0]  pin_async,
    output logic      [PCI_PORT_WIDTH-1:0]  pin_sync
);
    import pci_pkg::*;

    logic [PCI_PORT_WIDTH-1:0] meta_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q   <= PCI_ZERO8;
            pin_sync <= PCI_ZERO8;
        end
        else
        begin
            meta_q   <= pin_async;
            pin_sync <= meta_q;
        end
    end
endmodule

// ### pci_top.sv
// pin-change interrupt controller with apb register access
// What this block does
// - master enable clear: edges still flag, but change_irq not raised; irq is not gated by it
// - each pin has a rising detector armed by its rise enable bit
// - each pin has a falling detector armed by its fall enable bit
// - both enables set flags edges in either direction
// - enabled edge sets pin flag; interrupt if master enable set
// - first-port flag set by enabled rising or enabled falling edge
// - summary flag is OR of all per-pin flags of both ports
// - software clears a flag by writing zero; hardware sets independently
// - edge during a flag write leaves that flag set
// - flagged change wakes device from sleep when master enable set
// - edge in sleep is recorded before wake is signalled
// - first port implements bits five to zero; seven and six read zero
// - second port rise enable implements bits seven to four only
// - second port fall enable implements bits seven to four only
// - second port flags bits seven to four, set by edges, cleared by zero
//
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ns
module pci_top
    import pci_pkg::*;
(
    // clock and reset
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    // apb slave
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [11:0]                paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    // port pins
    input  wire logic [PCI_PORT_WIDTH-1:0]  porta_pin,
    input  wire logic [PCI_PORT_WIDTH-1:0]  portb_pin,
    // system
    input  wire logic                       sleeping,
    output logic                            wake_req,
    output logic                            change_irq,
    output logic                            irq
);
    import pci_pkg::*;

    // ************************************************************
    // bus decode
    // ************************************************************
    pci_apb_req_t req;
    logic         wr_en;
    logic         rd_en;
    logic         addr_ok;

    assign req     = '{psel: psel, penable: penable, pwrite: pwrite,
                       paddr: paddr, pwdata: pwdata};
    assign wr_en   = req.psel & req.penable & req.pwrite;
    assign rd_en   = req.psel & req.penable & ~req.pwrite;
    assign pready  = 1'b1;

    always_comb
    begin
        addr_ok = 1'b1;
        if (req.paddr == PCI_PORTA_RISE_OFF)
            addr_ok = 1'b1;
        else if (req.paddr == PCI_PORTA_FALL_OFF)
            addr_ok = 1'b1;
        else if (req.paddr == PCI_PORTA_FLAG_OFF)
            addr_ok = 1'b1;
        else if (req.paddr == PCI_PORTB_RISE_OFF)
            addr_ok = 1'b1;
        else if (req.paddr == PCI_PORTB_FALL_OFF)
            addr_ok = 1'b1;
        else if (req.paddr == PCI_PORTB_FLAG_OFF)
            addr_ok = 1'b1;
        else if (req.paddr == PCI_INTCTL_OFF)
            addr_ok = 1'b1;
        else if (req.paddr == PCI_IRQ_STATUS_OFF)
            addr_ok = 1'b1;
        else if (req.paddr == PCI_IRQ_CLEAR_OFF)
            addr_ok = 1'b1;
        else if (req.paddr == PCI_IRQ_ENABLE_OFF)
            addr_ok = 1'b1;
        else
            addr_ok = 1'b0;
    end

    assign pslverr = req.psel & req.penable & ~addr_ok;

    // ************************************************************
    // enable registers
    // ************************************************************
    pci_edge_cfg_t porta_cfg_q;
    pci_edge_cfg_t portb_cfg_q;
    logic          master_en_q;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            porta_cfg_q <= '{rise: PCI_ZERO8, fall: PCI_ZERO8};
            portb_cfg_q <= '{rise: PCI_ZERO8, fall: PCI_ZERO8};
        end
        else if (wr_en)
        begin
            // unimplemented bits held at zero
            if (req.paddr == PCI_PORTA_RISE_OFF)
                porta_cfg_q.rise <= req.pwdata[7:0] & PCI_PORTA_MASK;
            else if (req.paddr == PCI_PORTA_FALL_OFF)
                porta_cfg_q.fall <= req.pwdata[7:0] & PCI_PORTA_MASK;
            else if (req.paddr == PCI_PORTB_RISE_OFF)
                portb_cfg_q.rise <= req.pwdata[7:0] & PCI_PORTB_MASK;
            else if (req.paddr == PCI_PORTB_FALL_OFF)
                portb_cfg_q.fall <= req.pwdata[7:0] & PCI_PORTB_MASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            master_en_q <= 1'b0;
        else if (wr_en && req.paddr == PCI_INTCTL_OFF)
            master_en_q <= req.pwdata[PCI_INTCTL_MEN_BIT];
    end

    // ************************************************************
    // synchronisers and edge detectors
    // ************************************************************
    logic [PCI_PORT_WIDTH-1:0] porta_sync;
    logic [PCI_PORT_WIDTH-1:0] portb_sync;
    logic [PCI_PORT_WIDTH-1:0] porta_hit;
    logic [PCI_PORT_WIDTH-1:0] portb_hit;

    pci_sync u_sync_a
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_async (porta_pin),
        .pin_sync  (porta_sync)
    );

    pci_sync u_sync_b
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_async (portb_pin),
        .pin_sync  (portb_sync)
    );

    pci_edge u_edge_a
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_sync  (porta_sync),
        .cfg       (porta_cfg_q),
        .hit       (porta_hit)
    );

    pci_edge u_edge_b
    (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_sync  (portb_sync),
        .cfg       (portb_cfg_q),
        .hit       (portb_hit)
    );

    // ************************************************************
    // per-pin flags
    // ************************************************************
    logic [7:0] porta_flag_q;
    logic [7:0] porta_flag_d;
    logic [7:0] portb_flag_q;
    logic [7:0] portb_flag_d;

    always_comb
    begin
        porta_flag_d = porta_flag_q;
        portb_flag_d = portb_flag_q;
        if (wr_en && req.paddr == PCI_PORTA_FLAG_OFF)
            porta_flag_d = porta_flag_q & req.pwdata[7:0];
        if (wr_en && req.paddr == PCI_PORTB_FLAG_OFF)
            portb_flag_d = portb_flag_q & req.pwdata[7:0];
        // set wins over a simultaneous clear
        porta_flag_d = (porta_flag_d | porta_hit) & PCI_PORTA_MASK;
        portb_flag_d = (portb_flag_d | portb_hit) & PCI_PORTB_MASK;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            porta_flag_q <= PCI_ZERO8;
            portb_flag_q <= PCI_ZERO8;
        end
        else
        begin
            porta_flag_q <= porta_flag_d;
            portb_flag_q <= portb_flag_d;
        end
    end

    // ************************************************************
    // summary, interrupt and wake
    // ************************************************************
    logic summary_flag;

    assign summary_flag = (|porta_flag_q) | (|portb_flag_q);
    // detection continues regardless; only the request is gated
    assign change_irq   = summary_flag & master_en_q;
    // flags are already registered when wake rises
    assign wake_req     = sleeping & change_irq;

    // ************************************************************
    // event status, enable and clear
    // ************************************************************
    logic [PCI_EV_WIDTH-1:0] ev_status_q;
    logic [PCI_EV_WIDTH-1:0] ev_enable_q;
    logic [PCI_EV_WIDTH-1:0] ev_set;
    logic [PCI_EV_WIDTH-1:0] ev_clr;

    assign ev_set[PCI_EV_PORTA_BIT] = |porta_hit;
    assign ev_set[PCI_EV_PORTB_BIT] = |portb_hit;
    assign ev_clr = (wr_en && req.paddr == PCI_IRQ_CLEAR_OFF) ?
                    req.pwdata[PCI_EV_WIDTH-1:0] : PCI_EV_ZERO;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ev_status_q <= PCI_EV_ZERO;
        else
            ev_status_q <= (ev_status_q & ~ev_clr) | ev_set;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ev_enable_q <= PCI_EV_ZERO;
        else if (wr_en && req.paddr == PCI_IRQ_ENABLE_OFF)
            ev_enable_q <= req.pwdata[PCI_EV_WIDTH-1:0];
    end

    assign irq = |(ev_status_q & ev_enable_q);

    // ************************************************************
    // read data
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= PCI_ZERO32;
        else if (req.psel && !req.penable && !req.pwrite)
        begin
            prdata <= PCI_ZERO32;
            if (req.paddr == PCI_PORTA_RISE_OFF)
                prdata[7:0] <= porta_cfg_q.rise;
            else if (req.paddr == PCI_PORTA_FALL_OFF)
                prdata[7:0] <= porta_cfg_q.fall;
            else if (req.paddr == PCI_PORTA_FLAG_OFF)
                prdata[7:0] <= porta_flag_d;
            else if (req.paddr == PCI_PORTB_RISE_OFF)
                prdata[7:0] <= portb_cfg_q.rise;
            else if (req.paddr == PCI_PORTB_FALL_OFF)
                prdata[7:0] <= portb_cfg_q.fall;
            else if (req.paddr == PCI_PORTB_FLAG_OFF)
                prdata[7:0] <= portb_flag_d;
            else if (req.paddr == PCI_INTCTL_OFF)
            begin
                prdata[PCI_INTCTL_MEN_BIT] <= master_en_q;
                prdata[PCI_INTCTL_SUM_BIT] <= (|porta_flag_d) | (|portb_flag_d);
            end
            else if (req.paddr == PCI_IRQ_STATUS_OFF)
                prdata[PCI_EV_WIDTH-1:0] <= ev_status_q | ev_set;
            else if (req.paddr == PCI_IRQ_ENABLE_OFF)
                prdata[PCI_EV_WIDTH-1:0] <= ev_enable_q;
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    property p_no_irq_when_off;
        @(posedge pclk) disable iff (!presetn)
        !master_en_q |-> !change_irq;
    endproperty
    a_no_irq_when_off: assert property (p_no_irq_when_off)
        else $error("change irq raised with master enable clear");

    property p_rise_sets_flag;
        @(posedge pclk) disable iff (!presetn)
        (porta_cfg_q.rise[0] && porta_sync[0] && !$past(porta_sync[0]))
            |=> porta_flag_q[0];
    endproperty
    a_rise_sets_flag: assert property (p_rise_sets_flag)
        else $error("rising edge did not set flag");

    property p_fall_sets_flag;
        @(posedge pclk) disable iff (!presetn)
        (porta_cfg_q.fall[0] && !porta_sync[0] && $past(porta_sync[0]))
            |=> porta_flag_q[0];
    endproperty
    a_fall_sets_flag: assert property (p_fall_sets_flag)
        else $error("falling edge did not set flag");

    // summary bit read back agrees with the live flags
    property p_summary_or;
        @(posedge pclk) disable iff (!presetn)
        (req.psel && !req.penable && !req.pwrite && req.paddr == PCI_INTCTL_OFF)
            |=> (prdata[PCI_INTCTL_SUM_BIT] == summary_flag);
    endproperty
    a_summary_or: assert property (p_summary_or)
        else $error("summary flag mismatch");

    sequence s_flag_write_zero;
        wr_en && req.paddr == PCI_PORTA_FLAG_OFF && !req.pwdata[1] && !porta_hit[1];
    endsequence
    property p_clear_by_zero;
        @(posedge pclk) disable iff (!presetn)
        s_flag_write_zero |=> !porta_flag_q[1];
    endproperty
    a_clear_by_zero: assert property (p_clear_by_zero)
        else $error("flag not cleared by zero write");

    property p_set_beats_clear;
        @(posedge pclk) disable iff (!presetn)
        (wr_en && ((req.paddr == PCI_PORTA_FLAG_OFF && (|porta_hit))
                || (req.paddr == PCI_PORTB_FLAG_OFF && (|portb_hit))))
            |=> (((porta_flag_q & $past(porta_hit)) == $past(porta_hit))
                && ((portb_flag_q & $past(portb_hit)) == $past(portb_hit)));
    endproperty
    a_set_beats_clear: assert property (p_set_beats_clear)
        else $error("edge lost during flag write");

    // edge seen asleep must reach the flags and raise wake next cycle
    property p_wake;
        @(posedge pclk) disable iff (!presetn)
        (sleeping && master_en_q && ((|porta_hit) || (|portb_hit)))
            |=> (wake_req || !sleeping);
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake not requested");

    property p_unimpl_zero;
        @(posedge pclk) disable iff (!presetn)
        (porta_flag_q[7:6] == 2'h0) && (portb_flag_q[3:0] == 4'h0)
            && (porta_cfg_q.rise[7:6] == 2'h0) && (portb_cfg_q.fall[3:0] == 4'h0);
    endproperty
    a_unimpl_zero: assert property (p_unimpl_zero)
        else $error("unimplemented bit set");

endmodule

// ### test_pin_change_interrupt.sv
// self-checking testbench of the pin-change interrupt block
`timescale 1ns/1ns
module test_pin_change_interrupt;
    import pci_pkg::*;

    // ************************************************************
    // signals and state
    // ************************************************************
    logic         pclk, presetn, sleeping, pready, pslverr;
    logic         wake_req, change_irq, irq;
    logic [31:0]  prdata, q;
    logic [7:0]   nxt_a, nxt_b, porta_pin, portb_pin;
    logic [1:0]   lag;
    pci_apb_req_t req;
    logic [7:0]   ra, fa, rb, fb, pa, pb, na, nb, ea, eb, m;
    logic [1:0]   ev, en_ev;
    logic         men, err;
    int           fail_count, tests_run;

    pci_top pci_top_inst (.pclk(pclk), .presetn(presetn), .psel(req.psel),
        .penable(req.penable), .pwrite(req.pwrite), .paddr(req.paddr),
        .pwdata(req.pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .porta_pin(porta_pin), .portb_pin(portb_pin), .sleeping(sleeping),
        .wake_req(wake_req), .change_irq(change_irq), .irq(irq));

    pci_pin_model pci_pin_model_inst (.pclk(pclk), .presetn(presetn), .next_a(nxt_a),
        .next_b(nxt_b), .lag(lag), .porta_pin(porta_pin), .portb_pin(portb_pin));

    // ************************************************************
    // tasks and functions
    // ************************************************************
    task automatic wrap_up;
        if (fail_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // one apb transfer: setup, then access until pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rdat, output logic rerr);
        int n;
        n = 0;
        @(posedge pclk);
        req <= '{1'b1, 1'b0, wr, a, d};
        @(posedge pclk);
        req.penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 32)
        begin
            @(posedge pclk);
            n++;
        end
        rdat = prdata;
        rerr = pslverr;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (n >= 32)
        begin
            fail_count++;
            wrap_up();
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'b1, a, {24'h0, d}, q, err);
    endtask

    task automatic rd(input logic [11:0] a, input logic [7:0] exp);
        apb(1'b0, a, PCI_ZERO32, q, err);
        chk(q, {24'h0, exp});
        chk({31'h0, err}, 32'h0);
    endtask

    function automatic logic [7:0] hits(input logic [7:0] o, n, r, f, msk);
        return ((~o & n & r) | (o & ~n & f)) & msk;
    endfunction

    // ************************************************************
    // main sequence
    // ************************************************************
    initial
    begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    initial
    begin
        req = '0;
        presetn = 1'b0;
        sleeping = 1'b0;
        nxt_a = 8'h00;
        nxt_b = 8'h00;
        lag = 2'h0;
        fail_count = 0;
        tests_run = 0;
        {pa, pb, ea, eb, ev} = '0;
        void'($urandom(97381));
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int k = 0; k < 8; k++)
            rd(12'(k * 4), PCI_ZERO8);
        wr(PCI_IRQ_STATUS_OFF, 8'h03);
        rd(PCI_IRQ_STATUS_OFF, PCI_ZERO8);
        apb(1'b1, 12'h030, 32'h0000_00ff, q, err);
        chk({31'h0, err}, 32'h1);
        apb(1'b0, 12'h030, PCI_ZERO32, q, err);
        chk(q, PCI_ZERO32);
        chk({31'h0, err}, 32'h1);
        for (int i = 0; i < 40; i++)
        begin
            {ra, fa, rb, fb, m} = 40'({$urandom, $urandom});
            {men, en_ev} = 3'($urandom);
            if (i % 8 == 0)
                {ra, fa, rb, fb} = '1;
            sleeping <= 1'($urandom);
            wr(PCI_PORTA_RISE_OFF, ra);
            wr(PCI_PORTA_FALL_OFF, fa);
            wr(PCI_PORTB_RISE_OFF, rb);
            wr(PCI_PORTB_FALL_OFF, fb);
            wr(PCI_INTCTL_OFF, {4'h0, men, 3'h0});
            wr(PCI_IRQ_ENABLE_OFF, {6'h0, en_ev});
            rd(PCI_PORTA_RISE_OFF, ra & PCI_PORTA_MASK);
            rd(PCI_PORTA_FALL_OFF, fa & PCI_PORTA_MASK);
            rd(PCI_PORTB_RISE_OFF, rb & PCI_PORTB_MASK);
            rd(PCI_PORTB_FALL_OFF, fb & PCI_PORTB_MASK);
            {na, nb} = 16'($urandom);
            lag <= 2'($urandom);
            nxt_a <= na;
            nxt_b <= nb;
            ea |= hits(pa, na, ra, fa, PCI_PORTA_MASK);
            eb |= hits(pb, nb, rb, fb, PCI_PORTB_MASK);
            ev |= {|hits(pb, nb, rb, fb, PCI_PORTB_MASK), |hits(pa, na, ra, fa, PCI_PORTA_MASK)};
            {pa, pb} = {na, nb};
            repeat (10) @(posedge pclk);
            rd(PCI_PORTA_FLAG_OFF, ea);
            rd(PCI_PORTB_FLAG_OFF, eb);
            rd(PCI_INTCTL_OFF, {4'h0, men, 2'h0, |(ea | eb)});
            rd(PCI_IRQ_STATUS_OFF, {6'h0, ev});
            @(negedge pclk);
            chk({31'h0, change_irq}, {31'h0, men & |(ea | eb)});
            chk({31'h0, wake_req}, {31'h0, sleeping & men & |(ea | eb)});
            chk({31'h0, irq}, {31'h0, |(ev & en_ev)});
            // software clears a random subset: port A writes expected flags and ~m, port B expected flags and m
            wr(PCI_PORTA_FLAG_OFF, ea & ~m);
            wr(PCI_PORTB_FLAG_OFF, eb & m);
            {ea, eb} = {ea & ~m, eb & m};
            wr(PCI_IRQ_CLEAR_OFF, {6'h0, m[1:0]});
            ev &= ~m[1:0];
        end
        // edge landing before, on and after the clearing write
        lag <= 2'h0;
        wr(PCI_PORTA_RISE_OFF, 8'h01);
        wr(PCI_PORTA_FALL_OFF, 8'h01);
        for (int j = 0; j < 4; j++)
        begin
            wr(PCI_PORTA_FLAG_OFF, 8'h00);
            @(posedge pclk);
            nxt_a <= pa ^ 8'h01;
            pa = pa ^ 8'h01;
            repeat (j) @(posedge pclk);
            wr(PCI_PORTA_FLAG_OFF, 8'h00);
            repeat (6) @(posedge pclk);
            rd(PCI_PORTA_FLAG_OFF, {7'h0, j <= 1});
        end
        wrap_up();
    end
endmodule
